// *** dv/sscf_card_model.sv ***
/*
  card side of both sockets: pin levels only.
  assumes the bench calls flip just after a falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module sscf_card_model (
  // card pins per socket
  output var logic [1:0] card_detect_first_n,
  output var logic [1:0] card_detect_second_n,
  output var logic [1:0] card_ready,
  output var logic [1:0] bvd1_n,
  output var logic [1:0] bvd2_n
);
  // pins always driven: card inserted, ready low, batteries good
  initial begin
    card_detect_first_n = 2'h0;
    card_detect_second_n = 2'h0;
    card_ready = 2'h0;
    bvd1_n = 2'h3;
    bvd2_n = 2'h3;
  end
  // kind 0/1 detect pins, 2 ready, 3 battery low, 4 battery dead
  task automatic flip(input int s, input int k);
    case (k)
      0: card_detect_first_n[s] = !card_detect_first_n[s];
      1: card_detect_second_n[s] = !card_detect_second_n[s];
      2: card_ready[s] = !card_ready[s];
      3: bvd2_n[s] = !bvd2_n[s];
      default: bvd1_n[s] = !bvd1_n[s];
    endcase
  endtask
endmodule

`default_nettype wire

// *** dv/sscf_top_chk.sv ***
/*
  port assertions for the status-change flag block.
  assumes it is bound to sscf_top, single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module sscf_top_chk (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic global_reset,
  input wire logic bus_reset,
  input wire logic power_mgmt_event_enable,
  // mode inputs
  input wire logic [1:0] card_is_io,
  input wire logic [1:0] ring_enable,
  // register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_legacy,
  input wire logic reg_socket,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  // requests
  input wire logic [1:0] status_irq,
  input wire logic [1:0] status_irq_pci,
  input wire logic [1:0] status_irq_isa,
  input wire logic [1:0][3:0] status_irq_route_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] wr_hi;
  assign wr_hi = reg_wdata[7:4];
  logic quiet;
  // any of these may legally drop a flag, so hold is judged without them
  assign quiet = !reg_rd && !reg_wr && !global_reset && !bus_reset;
  sequence s_rd(a);
    reg_rd && !reg_legacy && !reg_socket && reg_addr == a;
  endsequence
  sequence s_cfg_wr;
    reg_wr && !reg_legacy && !reg_socket && reg_addr == 12'h805;
  endsequence
  ////////////////////////////////////////////////////////////////////
  property p_vld; reg_rd |=> reg_rd_valid; endproperty
  a_vld: assert property (p_vld) else $error("read not answered");
  property p_hi; s_rd(12'h804) |=> reg_rdata[7:4] == 4'h0; endproperty
  a_hi: assert property (p_hi) else $error("flag top bits set");
  property p_io;
    s_rd(12'h804) ##0 card_is_io[0] && $past(card_is_io[0])
      |=> reg_rdata[2:1] == 2'h0;
  endproperty
  a_io: assert property (p_io) else $error("io card bits set");
  property p_unm; s_rd(12'h806) |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not zero");
  property p_global_reset;
    global_reset |=> status_irq == 2'h0 &&
      status_irq_route_select == 8'h00;
  endproperty
  a_global_reset: assert property (p_global_reset) else $error("global reset kept state");
  property p_brst;
    bus_reset && !power_mgmt_event_enable |=> status_irq == 2'h0;
  endproperty
  a_brst: assert property (p_brst) else $error("bus reset kept flags");
  property p_cfg;
    s_cfg_wr ##0 !global_reset && !bus_reset
      |=> status_irq_route_select[0] == $past(wr_hi);
  endproperty
  a_cfg: assert property (p_cfg) else $error("route not stored");
  property p_hold;
    status_irq[0] && quiet && $stable(card_is_io) && $stable(ring_enable)
      |=> status_irq[0];
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_isa;
    status_irq_isa[0] |-> status_irq[0] &&
      status_irq_route_select[0] != 4'h0;
  endproperty
  a_isa: assert property (p_isa) else $error("bad legacy request");
  property p_pci;
    status_irq_pci[0] |-> status_irq[0] &&
      status_irq_route_select[0] == 4'h0;
  endproperty
  a_pci: assert property (p_pci) else $error("bad pci request");
endmodule

bind sscf_top sscf_top_chk sscf_top_chk_inst (.clk, .rst, .global_reset,
  .bus_reset, .power_mgmt_event_enable, .card_is_io, .ring_enable,
  .reg_rd, .reg_wr, .reg_legacy, .reg_socket, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_rd_valid, .status_irq, .status_irq_pci,
  .status_irq_isa, .status_irq_route_select);

`default_nettype wire

// *** dv/sscf_top_tb_top.sv ***
/*
  self-checking bench for sscf_top with a card pin model.
  assumes the checker is bound in; reads are scored by a monitor.
*/
`timescale 1ns/1ps
`default_nettype none

module sscf_top_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic global_reset, bus_reset, power_mgmt_event_enable;
  logic diag_status_route_pci, reg_rd, reg_wr, reg_legacy, reg_socket;
  logic reg_rd_valid;
  logic [1:0] card_is_io, ring_enable, status_route_pci;
  logic [1:0] status_irq, status_irq_pci, status_irq_isa;
  logic [1:0][3:0] status_irq_route_select;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [7:0] exp_q[$];
  logic [7:0] tbl[5] = '{8'h08, 8'h08, 8'h04, 8'h02, 8'h01};
  wire logic [1:0] card_detect_first_n, card_detect_second_n;
  wire logic [1:0] card_ready, bvd1_n, bvd2_n;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 32'h5fe3a550;

  sscf_card_model sscf_card_model_inst (.card_detect_first_n,
    .card_detect_second_n, .card_ready, .bvd1_n, .bvd2_n);
  sscf_top sscf_top_inst (.clk, .rst, .global_reset, .bus_reset,
    .power_mgmt_event_enable, .card_is_io, .ring_enable, .status_route_pci,
    .diag_status_route_pci, .card_detect_first_n, .card_detect_second_n,
    .card_ready, .bvd1_n, .bvd2_n, .reg_rd, .reg_wr, .reg_legacy,
    .reg_socket, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
    .status_irq, .status_irq_pci, .status_irq_isa, .status_irq_route_select);

  initial begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic final_report();
    // a read that was never answered must not slip through
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("ERROR pending reads expected 0 seen %0d", exp_q.size());
    end
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] x,
                     input logic [7:0] g);
    num_checks++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  // one strobe cycle; for a read d is the expected data
  task automatic acc(input logic w, input logic l, input logic s,
                     input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = w;
    reg_rd = !w;
    reg_legacy = l;
    reg_socket = s;
    reg_addr = a;
    reg_wdata = d;
    if (!w)
      exp_q.push_back(d);
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic ev(input int s, input int k);
    @(negedge clk);
    sscf_card_model_inst.flip(s, k);
    repeat (3) @(negedge clk);
  endtask
  task automatic pulse(input logic g);
    @(negedge clk);
    global_reset = g;
    bus_reset = !g;
    @(negedge clk);
    global_reset = 1'b0;
    bus_reset = 1'b0;
  endtask
  // read valid stands one cycle, so the data is taken at that cycle only
  always @(posedge clk) begin
    #1;
    if (reg_rd_valid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("read count", 8'h00, 8'hff);
      else
        chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
    cyc++;
    if (cyc > 5000) begin
      num_errors++;
      $display("ERROR cycle limit expected 5000 seen %0d", cyc);
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    {reg_rd, reg_wr, reg_legacy, reg_socket} = 4'h0;
    {global_reset, bus_reset, diag_status_route_pci} = 3'h1;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    power_mgmt_event_enable = 1'b1;
    card_is_io = 2'h0;
    ring_enable = 2'h0;
    status_route_pci = 2'($random(seed));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int s = 0; s < 2; s++) begin
      acc(0, 0, s, 12'h804, 8'h00);
      acc(0, 0, s, 12'h805, 8'h00);
    end
    acc(0, 0, 0, 12'h806, 8'h00);
    ev(0, 0);
    acc(0, 1, 0, 12'h004, 8'h00);
    // route 1 so the legacy request path is taken
    acc(1, 0, 0, 12'h805, 8'h1f);
    for (int k = 0; k < 5; k++) begin
      ev(0, k);
      chk("status_irq", 8'h01, {7'h0, status_irq[0]});
      chk("status_irq_isa", 8'h01, {7'h0, status_irq_isa[0]});
      acc(0, 1, 0, 12'h004, tbl[k]);
      acc(0, 1, 0, 12'h004, 8'h00);
    end
    for (int k = 2; k < 5; k++)
      ev(0, k);
    acc(0, 0, 0, 12'h804, 8'h00);
    acc(1, 0, 0, 12'h805, 8'h0f);
    acc(1, 0, 0, 12'h81e, 8'h04);
    acc(0, 1, 0, 12'h01e, 8'h04);
    ev(0, 0);
    chk("status_irq_pci", 8'h01, {7'h0, status_irq_pci[0]});
    acc(0, 0, 0, 12'h804, 8'h08);
    acc(0, 0, 0, 12'h804, 8'h08);
    acc(1, 0, 0, 12'h804, 8'h08);
    acc(0, 0, 0, 12'h804, 8'h00);
    ev(0, 1);
    acc(1, 0, 0, 12'h805, 8'h07);
    acc(0, 0, 0, 12'h804, 8'h00);
    acc(1, 0, 0, 12'h805, 8'h0f);
    ev(0, 1);
    pulse(1'b0);
    acc(0, 0, 0, 12'h804, 8'h08);
    power_mgmt_event_enable = 1'b0;
    pulse(1'b0);
    acc(0, 0, 0, 12'h804, 8'h00);
    acc(0, 0, 0, 12'h805, 8'h00);
    acc(1, 0, 0, 12'h805, 8'h0f);
    card_is_io[0] = 1'b1;
    ev(0, 2);
    ev(0, 3);
    acc(0, 0, 0, 12'h804, 8'h00);
    ev(0, 4);
    acc(0, 0, 0, 12'h804, 8'h01);
    acc(1, 0, 0, 12'h804, 8'h01);
    card_is_io[0] = 1'b0;
    ev(0, 2);
    ev(0, 3);
    // ring pin is low here, so the live level reads one
    ring_enable[0] = 1'b1;
    acc(0, 0, 0, 12'h804, 8'h01);
    ev(0, 4);
    acc(0, 0, 0, 12'h804, 8'h00);
    ring_enable[0] = 1'b0;
    acc(1, 1, 0, 12'h045, 8'h0f);
    ev(1, 0);
    chk("status_irq", 8'h02, {6'h0, status_irq});
    acc(0, 1, 0, 12'h044, 8'h08);
    rv = 8'($random(seed));
    acc(1, 1, 0, 12'h045, rv);
    acc(0, 0, 1, 12'h805, rv);
    chk("route select", {4'h0, rv[7:4]},
        {4'h0, status_irq_route_select[1]});
    pulse(1'b1);
    acc(0, 1, 0, 12'h045, 8'h00);
    repeat (4) @(negedge clk);
    final_report();
  end
endmodule

`default_nettype wire

// *** logic/sscf_edge.sv ***
/*
  samples one socket's card pins and turns changes into one-cycle
  set events. assumes pins already synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

`include "sscf_regs.svh"

module sscf_edge
  import sscf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // card pins, active low where named so
  input wire logic card_detect_first_n,
  input wire logic card_detect_second_n,
  input wire logic card_ready,
  input wire logic bvd1_n,
  input wire logic bvd2_n,
  // events to the flag store
  sscf_evt_if.src ev
);

  sscf_edge_s st_r;
  sscf_edge_s st_nxt;

  always_comb begin
    st_nxt = '{primed: 1'b1, det_first_n: card_detect_first_n,
               det_second_n: card_detect_second_n, ready: card_ready,
               bvd1_n: bvd1_n, bvd2_n: bvd2_n};
    // re-prime after a context clear so no false change is seen
    if (rst || ev.ctx_clear) begin
      st_nxt.primed = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  always_comb begin
    ev.set_evt = 4'h0;
    ev.set_evt[`SSCF_BIT_CD] = st_r.primed &&
      ((st_r.det_first_n != card_detect_first_n) ||
       (st_r.det_second_n != card_detect_second_n));
    ev.set_evt[`SSCF_BIT_READY] = st_r.primed && !ev.is_io &&
      card_ready && !st_r.ready;
    ev.set_evt[`SSCF_BIT_BLOW] = st_r.primed && !ev.is_io &&
      !bvd2_n && st_r.bvd2_n;
    // same pin carries battery dead or status change; ring mode
    // reports the live level instead of latching
    ev.set_evt[`SSCF_BIT_BDEAD] = st_r.primed && !ev.ring_en &&
      !bvd1_n && st_r.bvd1_n;
  end

  assign ev.ring_level = !st_r.bvd1_n;

endmodule

`default_nettype wire

// *** logic/sscf_evt_if.sv ***
/*
  per-socket carrier between pin sampler, flag store and the top.
  assumes one instance per socket, all on one clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface sscf_evt_if;
  logic [3:0] set_evt;
  logic ring_level;
  logic [3:0] enable;
  logic is_io;
  logic ring_en;
  logic [3:0] clr_mask;
  logic ctx_clear;
  logic [3:0] flags;

  modport src (output set_evt, output ring_level,
               input is_io, input ring_en, input ctx_clear);
  modport flg (input set_evt, input enable, input is_io,
               input clr_mask, input ctx_clear, output flags);
  modport ctl (input ring_level, input flags, output enable,
               output is_io, output ring_en, output clr_mask,
               output ctx_clear);
endinterface

`default_nettype wire

// *** logic/sscf_flags.sv ***
/*
  sticky status-change flags of one socket.
  assumes the top supplies enables, clear mask and context clear.
*/
`timescale 1ns/1ps
`default_nettype none

`include "sscf_regs.svh"

module sscf_flags
  import sscf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control and result
  sscf_evt_if.flg ev
);

  sscf_flag_s st_r;
  sscf_flag_s st_nxt;

  always_comb begin
    st_nxt.flags = st_r.flags & ~ev.clr_mask;
    // set after clear: an event in the clearing cycle survives
    st_nxt.flags = st_nxt.flags | (ev.set_evt & ev.enable);
    st_nxt.flags = st_nxt.flags & ev.enable;
    if (ev.is_io) begin
      st_nxt.flags[`SSCF_BIT_READY] = 1'b0;
      st_nxt.flags[`SSCF_BIT_BLOW] = 1'b0;
    end
    if (rst || ev.ctx_clear) begin
      st_nxt.flags = `SSCF_RST_FLAGS;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign ev.flags = st_r.flags;

endmodule

`default_nettype wire

// *** logic/sscf_pkg.sv ***
/*
  types shared by the socket status-change flag block.
  assumes sscf_regs.svh supplies the numeric constants.
*/
package sscf_pkg;

  typedef enum logic [1:0] {
    SSCF_REG_NONE  = 2'b00,
    SSCF_REG_FLAGS = 2'b01,
    SSCF_REG_CFG   = 2'b10,
    SSCF_REG_GCTL  = 2'b11
  } sscf_reg_e;

  typedef struct packed {
    logic primed;
    logic det_first_n;
    logic det_second_n;
    logic ready;
    logic bvd1_n;
    logic bvd2_n;
  } sscf_edge_s;

  typedef struct packed {
    logic [3:0] flags;
  } sscf_flag_s;

  typedef struct packed {
    logic [1:0][7:0] cfg;
    logic [1:0] w1c;
    logic [7:0] rdata;
    logic rd_valid;
  } sscf_top_s;

endpackage

// *** logic/sscf_regs.svh ***
/*
  register offsets, field positions, reset values for the socket
  status-change flag block. assumes nothing; definitions only.
*/
`ifndef SSCF_REGS_SVH
`define SSCF_REGS_SVH

// socket register window offsets
`define SSCF_OFF_FLAGS 12'h804
`define SSCF_OFF_CFG 12'h805
`define SSCF_OFF_GCTL 12'h81e

// legacy index space, low six bits; bit 6 picks the socket
`define SSCF_IDX_FLAGS 6'h04
`define SSCF_IDX_CFG 6'h05
`define SSCF_IDX_GCTL 6'h1e
`define SSCF_IDX_SOCK_BIT 6

// flag and enable bit positions
`define SSCF_BIT_CD 3
`define SSCF_BIT_READY 2
`define SSCF_BIT_BLOW 1
`define SSCF_BIT_BDEAD 0

// configuration fields
`define SSCF_CFG_EN_MSB 3
`define SSCF_CFG_ROUTE_LSB 4
`define SSCF_CFG_ROUTE_MSB 7
`define SSCF_ROUTE_NONE 4'h0

// global control: flag clear mode, 1 = write one to clear
`define SSCF_GCTL_W1C_BIT 2

// reset values
`define SSCF_RST_FLAGS 4'h0
`define SSCF_RST_CFG 8'h00
`define SSCF_RST_GCTL 1'b0
`define SSCF_RST_RDATA 8'h00

`endif

// *** logic/sscf_top.sv ***
/*
  status-change flag logic for a two-socket card controller:
  register decode, configuration, clear modes and request routing.
  assumes card pins and register strobes synchronous to clk, and
  card type and ring mode supplied by the control register outside.
*/
//
// Contract
// - a disabled source's flag always reads zero
// - an enabled source's active condition sets its flag until cleared
// - flags clear on read or on writing one to the bit
// - global control bit 2 at 81eh picks the clear method
// - flag register bits 7 to 4 read zero
// - bit 3 sets on any change of either card-detect input
// - memory card: bit 2 sets on ready low-to-high transition
// - io card: bit 2 always reads zero
// - memory card: bit 1 sets on battery-low warning
// - io card: bit 1 always reads zero
// - bit 0 sets on battery dead or status-change assertion
// - ring mode: bit 0 shows the ring-indicate input level
// - flags clear on global reset, or bus reset without power events
// - one flag register per socket at 804h, index 04h or 44h
// - one config register per socket at 805h, index 05h or 45h
// - config register routes the request and masks each source
// - config bits 3 to 0 enable the four sources, default zero
// - config bits 7 to 4 pick the request line, zero selects none
//
`timescale 1ns/1ps
`default_nettype none

`include "sscf_regs.svh"

module sscf_top
  import sscf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // system resets and power management
  input wire logic global_reset,
  input wire logic bus_reset,
  input wire logic power_mgmt_event_enable,
  // per-socket configuration held elsewhere, plus one pci route bit shared by both sockets
  input wire logic [1:0] card_is_io,
  input wire logic [1:0] ring_enable,
  input wire logic [1:0] status_route_pci,
  input wire logic diag_status_route_pci,
  // card pins per socket
  input wire logic [1:0] card_detect_first_n,
  input wire logic [1:0] card_detect_second_n,
  input wire logic [1:0] card_ready,
  input wire logic [1:0] bvd1_n,
  input wire logic [1:0] bvd2_n,
  // register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_legacy,
  input wire logic reg_socket,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // status-change requests per socket
  output logic [1:0] status_irq,
  output logic [1:0] status_irq_pci,
  output logic [1:0] status_irq_isa,
  output logic [1:0][3:0] status_irq_route_select
);

  ////////////////////////////////////////////////////////////////////
  // address decode

  // both address forms land on the same per-socket registers
  function automatic sscf_reg_e sscf_decode(
    input logic legacy,
    input logic socket,
    input logic [11:0] addr,
    input logic sock
  );
    sscf_reg_e r;
    r = SSCF_REG_NONE;
    if (legacy) begin
      if (addr[11:7] == 5'h00 && addr[`SSCF_IDX_SOCK_BIT] == sock) begin
        unique case (addr[5:0])
          `SSCF_IDX_FLAGS: r = SSCF_REG_FLAGS;
          `SSCF_IDX_CFG: r = SSCF_REG_CFG;
          `SSCF_IDX_GCTL: r = SSCF_REG_GCTL;
          default: r = SSCF_REG_NONE;
        endcase
      end
    end else if (socket == sock) begin
      unique case (addr)
        `SSCF_OFF_FLAGS: r = SSCF_REG_FLAGS;
        `SSCF_OFF_CFG: r = SSCF_REG_CFG;
        `SSCF_OFF_GCTL: r = SSCF_REG_GCTL;
        default: r = SSCF_REG_NONE;
      endcase
    end
    return r;
  endfunction

  // what software sees in the flag register
  function automatic logic [7:0] sscf_flag_view(
    input logic [3:0] flags,
    input logic [3:0] enable,
    input logic ring_en,
    input logic ring_level
  );
    logic [3:0] v;
    v = flags & enable;
    if (ring_en) begin
      v[`SSCF_BIT_BDEAD] = ring_level & enable[`SSCF_BIT_BDEAD];
    end
    return {4'h0, v};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // per-socket flag logic

  logic ctx_clear;
  logic [1:0][3:0] flags_w;
  logic [1:0] ring_level_w;
  logic [1:0][3:0] clr_mask;
  sscf_top_s st_r;
  sscf_top_s st_nxt;

  // context bits survive bus reset while power events are armed
  assign ctx_clear = global_reset ||
    (bus_reset && !power_mgmt_event_enable);

  for (genvar s = 0; s < 2; s++) begin : g_sock
    sscf_evt_if ev ();

    assign ev.enable = st_r.cfg[s][`SSCF_CFG_EN_MSB:0];
    assign ev.is_io = card_is_io[s];
    assign ev.ring_en = ring_enable[s];
    assign ev.clr_mask = clr_mask[s];
    assign ev.ctx_clear = ctx_clear;
    assign flags_w[s] = ev.flags;
    assign ring_level_w[s] = ev.ring_level;

    sscf_edge u_edge (
      .clk(clk),
      .rst(rst),
      .card_detect_first_n(card_detect_first_n[s]),
      .card_detect_second_n(card_detect_second_n[s]),
      .card_ready(card_ready[s]),
      .bvd1_n(bvd1_n[s]),
      .bvd2_n(bvd2_n[s]),
      .ev(ev.src)
    );

    sscf_flags u_flags (
      .clk(clk),
      .rst(rst),
      .ev(ev.flg)
    );
  end

  ////////////////////////////////////////////////////////////////////
  // register file

  always_comb begin
    sscf_reg_e sel;
    logic [7:0] view;
    sel = SSCF_REG_NONE;
    view = 8'h00;
    st_nxt = st_r;
    st_nxt.rd_valid = reg_rd;
    clr_mask = '0;
    if (reg_rd) begin
      st_nxt.rdata = `SSCF_RST_RDATA;
    end
    for (int s = 0; s < 2; s++) begin
      sel = sscf_decode(reg_legacy, reg_socket, reg_addr, s[0]);
      view = sscf_flag_view(flags_w[s], st_r.cfg[s][`SSCF_CFG_EN_MSB:0],
                            ring_enable[s], ring_level_w[s]);
      if (reg_wr) begin
        unique case (sel)
          SSCF_REG_CFG: st_nxt.cfg[s] = reg_wdata;
          SSCF_REG_GCTL: st_nxt.w1c[s] = reg_wdata[`SSCF_GCTL_W1C_BIT];
          SSCF_REG_FLAGS: begin
            // writes only clear in write-one mode; otherwise ignored
            if (st_r.w1c[s]) begin
              clr_mask[s] = reg_wdata[3:0];
            end
          end
          SSCF_REG_NONE: ;
        endcase
      end
      if (reg_rd) begin
        unique case (sel)
          SSCF_REG_FLAGS: begin
            st_nxt.rdata = view;
            // read-clear: a flag set in this same cycle still survives
            if (!st_r.w1c[s]) begin
              clr_mask[s] = 4'hf;
            end
          end
          SSCF_REG_CFG: st_nxt.rdata = st_r.cfg[s];
          SSCF_REG_GCTL: begin
            st_nxt.rdata = 8'h00;
            st_nxt.rdata[`SSCF_GCTL_W1C_BIT] = st_r.w1c[s];
          end
          SSCF_REG_NONE: ;
        endcase
      end
    end
    // enables and routing are context bits like the flags
    if (ctx_clear) begin
      st_nxt.cfg = {2{`SSCF_RST_CFG}};
    end
    if (global_reset) begin
      st_nxt.w1c = {2{`SSCF_RST_GCTL}};
    end
    if (rst) begin
      st_nxt.cfg = {2{`SSCF_RST_CFG}};
      st_nxt.w1c = {2{`SSCF_RST_GCTL}};
      st_nxt.rdata = `SSCF_RST_RDATA;
      st_nxt.rd_valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign reg_rdata = st_r.rdata;
  assign reg_rd_valid = st_r.rd_valid;

  ////////////////////////////////////////////////////////////////////
  // request routing

  // request follows flag flops, so it drops the cycle after the clear
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      status_irq[s] =
        |(flags_w[s] & st_r.cfg[s][`SSCF_CFG_EN_MSB:0]);
      status_irq_route_select[s] =
        st_r.cfg[s][`SSCF_CFG_ROUTE_MSB:`SSCF_CFG_ROUTE_LSB];
      status_irq_isa[s] = status_irq[s] &&
        (status_irq_route_select[s] != `SSCF_ROUTE_NONE);
      status_irq_pci[s] = status_irq[s] &&
        (status_irq_route_select[s] == `SSCF_ROUTE_NONE) &&
        (diag_status_route_pci || status_route_pci[s]);
    end
  end

endmodule

`default_nettype wire
